// >>> logic/ipc_pkg.sv
package ipc_pkg;
    // ===========================================================
    // bus register map (byte addresses)
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_IRQ_ST = 8'h08;
    localparam logic [7:0] A_IRQ_EN = 8'h0C;
    localparam logic [7:0] A_IRQ_CL = 8'h10;
    localparam logic [7:0] A_DEL    = 8'h14;
    localparam logic [7:0] A_MKEY   = 8'h20;
    localparam logic [7:0] A_WKEY   = 8'h40;
    localparam int         KEY_WRDS = 8;
    // ===========================================================
    // field positions
    localparam int CTRL_KDF_BIT  = 0;
    localparam int IRQ_TEST_DONE = 0;
    localparam int IRQ_TEST_FAIL = 1;
    localparam int IRQ_ECC_FATAL = 2;
    localparam int IRQ_DEL_DONE  = 3;
    localparam int IRQ_W         = 4;
    // ===========================================================
    // counts and reset values
    localparam int             NUM_CHECKS = 5;
    localparam int             ENTRY_WRDS = 8;
    localparam logic [31:0]    WORD_RST   = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RST  = 4'h0;
    localparam logic [2:0]     ERR_NONE   = 3'h0;

    typedef enum logic [4:0] {
        ST_INIT  = 5'b0_0001,
        ST_TEST  = 5'b0_0010,
        ST_READY = 5'b0_0100,
        ST_FAIL  = 5'b0_1000,
        ST_HARD  = 5'b1_0000
    } ipc_state_e;

    typedef struct packed {
        logic       valid;
        logic       crypto_en;
        logic       sa_valid;
        logic [1:0] proto;
    } ipc_meta_s;

    typedef struct packed {
        logic valid;
        logic crypto;
        logic flag;
    } ipc_dec_s;

    typedef struct packed {
        logic [255:0] master_key;
        logic [255:0] wrap_key;
    } ipc_keys_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [31:0] data;
    } ipc_dbw_s;
endpackage

// >>> logic/ipc_ctrl.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// Contract
// - key registers are write-only; reads of key words return zero
// - no key generation; keys come only from software or derivation
// - tunnel keys derived by CMAC counter KDF keyed by 256-bit master
// - master and wrap keys loaded by register write, never output
// - association keys reach the database only in wrapped form
// - reset clears every secret and state to zero and defaults
// - no independent soft reset; only system reset restarts engine
// - association delete writes zero to every word of the entry
// - self-test failure gives error code and a dead error state
// - after self-test failure no traffic, requests acked unprocessed; interrupt enable and clear writes still take effect
// - five known-answer checks run at init; no service until pass
// - each packet's metadata picks crypto or bypass exclusively
// - receive bypass writes crypto status zero
// - transmit result drop is 0 on success, 1 on soft error
// - transmit bypass writes drop zero
// - ECC failure raises fatal interrupt, hard error, frozen outputs
// - receive side derives tunnel key from tunnel master key
module ipc_ctrl (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_in,
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [7:0]        wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    output logic                   irq_out,
    output logic                   hard_err_out,
    output logic                   kat_start_out,
    output logic      [2:0]        kat_sel_out,
    input  wire logic              kat_done_in,
    input  wire logic              kat_pass_in,
    output logic                   kdf_start_out,
    output ipc_pkg::ipc_keys_s     dp_keys_out,
    input  wire ipc_pkg::ipc_meta_s rx_meta_in,
    output ipc_pkg::ipc_dec_s      rx_dec_out,
    input  wire ipc_pkg::ipc_meta_s tx_meta_in,
    output ipc_pkg::ipc_dec_s      tx_dec_out,
    input  wire logic              tx_done_in,
    input  wire logic              tx_soft_err_in,
    output ipc_pkg::ipc_dec_s      tx_res_out,
    input  wire logic [1:0]        ecc_err_in,
    input  wire ipc_pkg::ipc_dbw_s wrap_wr_in,
    output logic                   wrap_ready_out,
    output ipc_pkg::ipc_dbw_s      db_wr_out
);
    // ===========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic meta_ok(input ipc_pkg::ipc_meta_s m);
        return m.crypto_en && m.sa_valid && (m.proto != 2'b00);
    endfunction

    // ===========================================================
    // state
    ipc_pkg::ipc_state_e state_ff, nxt_state;
    logic [31:0]         mkey_ff [ipc_pkg::KEY_WRDS];
    logic [31:0]         wkey_ff [ipc_pkg::KEY_WRDS];
    logic [ipc_pkg::IRQ_W-1:0] ist_ff, ien_ff;
    logic [2:0]          chk_ff, err_ff;
    logic                kat_wait_ff;
    logic                del_busy_ff;
    logic [2:0]          del_cnt_ff;
    logic [15:0]         del_base_ff;

    // ===========================================================
    // bus decode
    wire         req     = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire         wr      = req && wb_we_in;
    wire         live    = (state_ff == ipc_pkg::ST_READY);
    wire         wr_ok   = wr && live;
    wire [2:0]   kidx    = wb_adr_in[4:2];
    wire         hit_mk  = wb_adr_in[7:5] == ipc_pkg::A_MKEY[7:5];
    wire         hit_wk  = wb_adr_in[7:5] == ipc_pkg::A_WKEY[7:5];
    wire         w_ctrl  = wr_ok && wb_adr_in == ipc_pkg::A_CTRL;
    wire         w_en    = wr && wb_adr_in == ipc_pkg::A_IRQ_EN;
    wire         w_clr   = wr && wb_adr_in == ipc_pkg::A_IRQ_CL;
    wire         w_del   = wr_ok && wb_adr_in == ipc_pkg::A_DEL
                           && !del_busy_ff;
    wire [3:0]   clr_bits = w_clr ? wb_dat_in[3:0] : 4'h0;
    wire         ecc_hit = |ecc_err_in;

    // key words and write-only regions read back as zero
    logic [31:0] rd_word;
    always_comb begin
        rd_word = ipc_pkg::WORD_RST;
        case (wb_adr_in)
            ipc_pkg::A_STATUS: rd_word = {24'h0, err_ff, state_ff};
            ipc_pkg::A_IRQ_ST: rd_word = {28'h0, ist_ff};
            ipc_pkg::A_IRQ_EN: rd_word = {28'h0, ien_ff};
            ipc_pkg::A_DEL:    rd_word = {31'h0, del_busy_ff};
            default:           rd_word = ipc_pkg::WORD_RST;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= ipc_pkg::WORD_RST;
        end else begin
            // requests in every state are answered; outside ready
            // only interrupt enable and clear writes have effect
            wb_ack_out <= req;
            wb_dat_out <= (req && !wb_we_in) ? rd_word
                                             : ipc_pkg::WORD_RST;
        end
    end

    // ===========================================================
    // key registers: written by software only, zeroed by reset
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < ipc_pkg::KEY_WRDS; i++) begin
                mkey_ff[i] <= ipc_pkg::WORD_RST;
                wkey_ff[i] <= ipc_pkg::WORD_RST;
            end
        end else if (wr_ok) begin
            if (hit_mk) begin
                mkey_ff[kidx] <= merge(mkey_ff[kidx], wb_dat_in,
                                       wb_sel_in);
            end
            if (hit_wk) begin
                wkey_ff[kidx] <= merge(wkey_ff[kidx], wb_dat_in,
                                       wb_sel_in);
            end
        end
    end

    // keys go only to the internal cores, and only when in service
    ipc_pkg::ipc_keys_s keys_w;
    always_comb begin
        keys_w = '0;
        for (int i = 0; i < ipc_pkg::KEY_WRDS; i++) begin
            keys_w.master_key[i*32 +: 32] = live ? mkey_ff[i] : '0;
            keys_w.wrap_key[i*32 +: 32]   = live ? wkey_ff[i] : '0;
        end
    end

    // ===========================================================
    // self-test sequencer and engine state
    wire kat_end  = kat_wait_ff && kat_done_in;
    wire kat_bad  = kat_end && !kat_pass_in;
    wire last_chk = chk_ff == 3'(ipc_pkg::NUM_CHECKS - 1);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ipc_pkg::ST_INIT:  nxt_state = ipc_pkg::ST_TEST;
            ipc_pkg::ST_TEST: begin
                if (kat_bad) begin
                    nxt_state = ipc_pkg::ST_FAIL;
                end else if (kat_end && last_chk) begin
                    nxt_state = ipc_pkg::ST_READY;
                end
            end
            ipc_pkg::ST_READY: nxt_state = ipc_pkg::ST_READY;
            ipc_pkg::ST_FAIL:  nxt_state = ipc_pkg::ST_FAIL;
            ipc_pkg::ST_HARD:  nxt_state = ipc_pkg::ST_HARD;
            default:           nxt_state = ipc_pkg::ST_FAIL;
        endcase
        if (ecc_hit) begin
            nxt_state = ipc_pkg::ST_HARD;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            // only system reset leaves HARD; FAIL is left by system reset or by an ECC error
            state_ff    <= ipc_pkg::ST_INIT;
            chk_ff      <= 3'h0;
            err_ff      <= ipc_pkg::ERR_NONE;
            kat_wait_ff <= 1'b0;
            kat_start_out <= 1'b0;
            kat_sel_out <= 3'h0;
        end else begin
            state_ff      <= nxt_state;
            kat_start_out <= 1'b0;
            if (state_ff == ipc_pkg::ST_INIT ||
                (kat_end && !kat_bad && !last_chk)) begin
                kat_start_out <= 1'b1;
                kat_sel_out   <= state_ff == ipc_pkg::ST_INIT ? 3'h0
                                 : chk_ff + 3'h1;
                chk_ff        <= state_ff == ipc_pkg::ST_INIT ? 3'h0
                                 : chk_ff + 3'h1;
                kat_wait_ff   <= 1'b1;
            end else if (kat_end) begin
                kat_wait_ff <= 1'b0;
            end
            if (kat_bad) begin
                err_ff <= chk_ff + 3'h1;
            end
        end
    end

    // ===========================================================
    // derivation trigger and interrupts
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            kdf_start_out <= 1'b0;
            dp_keys_out   <= '0;
            ist_ff        <= ipc_pkg::IRQ_RST;
            ien_ff        <= ipc_pkg::IRQ_RST;
            irq_out       <= 1'b0;
            hard_err_out  <= 1'b0;
        end else begin
            // master key drives the CMAC counter KDF
            kdf_start_out <= w_ctrl && wb_dat_in[ipc_pkg::CTRL_KDF_BIT];
            dp_keys_out   <= keys_w;
            if (w_en) begin
                ien_ff <= wb_dat_in[3:0];
            end
            // set wins over a clear in the same cycle
            ist_ff <= (ist_ff & ~clr_bits)
                | {del_busy_ff && del_cnt_ff == 3'(ipc_pkg::ENTRY_WRDS-1),
                   ecc_hit, kat_bad, kat_end && last_chk && !kat_bad};
            irq_out      <= |(ist_ff & ien_ff);
            hard_err_out <= nxt_state == ipc_pkg::ST_HARD;
        end
    end

    // ===========================================================
    // per-packet crypto / bypass choice
    wire rx_go = live && !ecc_hit && rx_meta_in.valid;
    wire tx_go = live && !ecc_hit && tx_meta_in.valid;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_dec_out <= '0;
            tx_dec_out <= '0;
            tx_res_out <= '0;
        end else if (!(state_ff == ipc_pkg::ST_HARD)) begin
            rx_dec_out.valid  <= rx_go;
            rx_dec_out.crypto <= rx_go && meta_ok(rx_meta_in);
            rx_dec_out.flag   <= rx_go && meta_ok(rx_meta_in);
            tx_dec_out.valid  <= tx_go;
            tx_dec_out.crypto <= tx_go && meta_ok(tx_meta_in);
            tx_dec_out.flag   <= 1'b0;
            tx_res_out.valid  <= live && !ecc_hit && tx_done_in;
            tx_res_out.crypto <= 1'b1;
            tx_res_out.flag   <= tx_done_in && tx_soft_err_in;
        end else begin
            rx_dec_out.valid <= 1'b0;
            tx_dec_out.valid <= 1'b0;
            tx_res_out.valid <= 1'b0;
        end
    end

    // ===========================================================
    // association database writes: zero fill or wrapped keys only
    wire del_last = del_cnt_ff == 3'(ipc_pkg::ENTRY_WRDS - 1);
    wire nxt_del  = w_del || (del_busy_ff && !del_last);
    wire wrap_acc = wrap_wr_in.valid && wrap_ready_out;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            del_busy_ff    <= 1'b0;
            del_cnt_ff     <= 3'h0;
            del_base_ff    <= 16'h0000;
            wrap_ready_out <= 1'b0;
            db_wr_out      <= '0;
        end else begin
            del_busy_ff    <= nxt_del && !ecc_hit;
            wrap_ready_out <= live && !ecc_hit && !nxt_del;
            if (w_del) begin
                del_base_ff <= wb_dat_in[15:0];
                del_cnt_ff  <= 3'h0;
            end else if (del_busy_ff) begin
                del_cnt_ff <= del_cnt_ff + 3'h1;
            end
            db_wr_out.valid <= !ecc_hit && (del_busy_ff || wrap_acc);
            db_wr_out.addr  <= del_busy_ff
                               ? del_base_ff + {13'h0, del_cnt_ff}
                               : wrap_wr_in.addr;
            db_wr_out.data  <= del_busy_ff ? ipc_pkg::WORD_RST
                               : wrap_wr_in.data;
        end
    end

    // ===========================================================
    // checks
    sequence s_ecc;
        ecc_hit;
    endsequence
    sequence s_frozen;
        !rx_dec_out.valid && !tx_dec_out.valid && !db_wr_out.valid;
    endsequence

    chk_hard_freeze: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) s_ecc |=> ##1 s_frozen [*3])
        else $error("outputs not frozen after ecc fault");
    chk_hard_sticky: assert property (@(posedge ref_clk_in)
        disable iff (reset_in)
        state_ff == ipc_pkg::ST_HARD |=> state_ff == ipc_pkg::ST_HARD)
        else $error("hard error state left without reset");
    chk_fail_sticky: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) kat_bad && !ecc_hit
        && state_ff == ipc_pkg::ST_TEST
        |=> state_ff == ipc_pkg::ST_FAIL && err_ff != ipc_pkg::ERR_NONE)
        else $error("self-test failure not latched");
    chk_no_traffic: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) !live |=> !rx_dec_out.valid)
        else $error("traffic forwarded while not in service");
    chk_test_first: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) $rose(live) |-> $past(kat_end)
        && $past(last_chk))
        else $error("service entered before all checks");
    chk_rx_bypass: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) rx_go && !meta_ok(rx_meta_in)
        |=> rx_dec_out.valid && !rx_dec_out.flag)
        else $error("rx bypass status not zero");
    chk_tx_drop: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) live && !ecc_hit && tx_done_in
        |=> tx_res_out.valid && tx_res_out.flag == $past(tx_soft_err_in))
        else $error("tx drop marker wrong");
    chk_tx_bypass: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) tx_dec_out.valid |-> !tx_dec_out.flag)
        else $error("tx bypass drop not zero");
    chk_del_zero: assert property (@(posedge ref_clk_in)
        disable iff (reset_in || state_ff == ipc_pkg::ST_HARD)
        w_del && !ecc_hit
        |=> ##1 (db_wr_out.valid && db_wr_out.data == '0) [*8])
        else $error("delete did not zero eight words");
    chk_key_hidden: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) req && !wb_we_in && (hit_mk || hit_wk)
        |=> wb_ack_out && wb_dat_out == '0)
        else $error("key word readable");
    chk_keys_gated: assert property (@(posedge ref_clk_in)
        disable iff (reset_in) !$past(live) |-> dp_keys_out == '0)
        else $error("keys driven while out of service");
endmodule

// >>> verification/ipc_upstream_model.sv
`timescale 1ns/1ps
// ===========================================================
// upstream packet processors and known-answer responder
module ipc_upstream_model (
    input  wire logic               clk_in,
    input  wire logic               kat_start_in,
    input  wire logic [2:0]         kat_sel_in,
    input  wire logic [2:0]         fail_sel_in,
    input  wire logic               soft_err_in,
    input  wire ipc_pkg::ipc_dec_s  tx_dec_in,
    output logic                    kat_done_out,
    output logic                    kat_pass_out,
    output logic                    tx_done_out,
    output logic                    tx_soft_err_out,
    output ipc_pkg::ipc_meta_s      rx_meta_out,
    output ipc_pkg::ipc_meta_s      tx_meta_out
);
    logic [2:0] sel;

    initial begin
        kat_done_out    = 1'b0;
        kat_pass_out    = 1'b0;
        tx_done_out     = 1'b0;
        tx_soft_err_out = 1'b0;
        rx_meta_out     = '0;
        tx_meta_out     = '0;
    end

    // one metadata word per packet, then idle with scrambled fields
    task automatic send_rx(input ipc_pkg::ipc_meta_s m);
        rx_meta_out <= m;
        @(posedge clk_in);
        rx_meta_out <= {1'b0, ~m[3:0]};
    endtask

    task automatic send_tx(input ipc_pkg::ipc_meta_s m);
        tx_meta_out <= m;
        @(posedge clk_in);
        tx_meta_out <= {1'b0, ~m[3:0]};
    endtask

    // latency grows with the check index: prompt and slow answers
    always begin
        @(posedge clk_in);
        if (kat_start_in === 1'b1) begin
            sel = kat_sel_in;
            repeat (sel + 1) @(posedge clk_in);
            kat_done_out <= 1'b1;
            kat_pass_out <= (sel != fail_sel_in);
            @(posedge clk_in);
            kat_done_out <= 1'b0;
            kat_pass_out <= (sel == fail_sel_in);
        end
    end

    always begin
        @(posedge clk_in);
        if (tx_dec_in.valid === 1'b1 && tx_dec_in.crypto === 1'b1) begin
            repeat (2) @(posedge clk_in);
            tx_done_out     <= 1'b1;
            tx_soft_err_out <= soft_err_in;
            @(posedge clk_in);
            tx_done_out     <= 1'b0;
            tx_soft_err_out <= ~soft_err_in;
        end
    end
endmodule

// >>> verification/ipc_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
end

module ipc_ctrl_tb;
    logic                ref_clk_in, reset_in, wb_cyc, wb_stb, wb_we;
    logic [7:0]          wb_adr;
    logic [31:0]         wb_dat, rdat, wb_dat_out;
    logic                wb_ack_out, irq_out, hard_err_out, kat_start_out;
    logic [2:0]          kat_sel_out, fail_sel;
    logic                kat_done, kat_pass, kdf_start_out, tx_done;
    logic                tx_soft, soft_err, wrap_ready_out, ex;
    logic [1:0]          ecc_err;
    ipc_pkg::ipc_keys_s  dp_keys_out;
    ipc_pkg::ipc_meta_s  rx_meta, tx_meta;
    ipc_pkg::ipc_dec_s   rx_dec_out, tx_dec_out, tx_res_out, d, r;
    ipc_pkg::ipc_dbw_s   wrap_wr, db_wr_out;
    ipc_pkg::ipc_dbw_s   dbq[$];
    int                  fails, n_tests, kdf_seen, i;

    ipc_ctrl i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
        .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_dat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .irq_out(irq_out), .hard_err_out(hard_err_out),
        .kat_start_out(kat_start_out), .kat_sel_out(kat_sel_out),
        .kat_done_in(kat_done), .kat_pass_in(kat_pass),
        .kdf_start_out(kdf_start_out), .dp_keys_out(dp_keys_out),
        .rx_meta_in(rx_meta), .rx_dec_out(rx_dec_out),
        .tx_meta_in(tx_meta), .tx_dec_out(tx_dec_out),
        .tx_done_in(tx_done), .tx_soft_err_in(tx_soft),
        .tx_res_out(tx_res_out), .ecc_err_in(ecc_err),
        .wrap_wr_in(wrap_wr), .wrap_ready_out(wrap_ready_out),
        .db_wr_out(db_wr_out));

    ipc_upstream_model i_up (.clk_in(ref_clk_in),
        .kat_start_in(kat_start_out), .kat_sel_in(kat_sel_out),
        .fail_sel_in(fail_sel), .soft_err_in(soft_err),
        .tx_dec_in(tx_dec_out), .kat_done_out(kat_done),
        .kat_pass_out(kat_pass), .tx_done_out(tx_done),
        .tx_soft_err_out(tx_soft), .rx_meta_out(rx_meta),
        .tx_meta_out(tx_meta));

    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    // ===========================================================
    // monitors
    always @(posedge ref_clk_in) begin
        if (db_wr_out.valid === 1'b1) dbq.push_back(db_wr_out);
        if (kdf_start_out === 1'b1) kdf_seen++;
    end

    // ===========================================================
    // tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] dw, output logic [31:0] q);
        int k;
        @(posedge ref_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= dw;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk_in);
            if (wb_ack_out === 1'b1) break;
        end
        q = wb_dat_out;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        if (k == 20) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dw);
        logic [31:0] q;
        wb(1'b1, a, dw, q);
    endtask

    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000, rdat);
    endtask

    task automatic do_reset;
        reset_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
    endtask

    task automatic wait_boot;
        for (int k = 0; k < 100; k++) begin
            rd(ipc_pkg::A_STATUS);
            if ((rdat[4:0] & 5'h0C) != 5'h00) return;
        end
        fails++;
        end_of_test();
    endtask

    task automatic pkt(input logic tx, input ipc_pkg::ipc_meta_s m);
        d = '0;
        r = '0;
        if (tx) i_up.send_tx(m);
        else i_up.send_rx(m);
        repeat (8) begin
            @(posedge ref_clk_in);
            if (!tx && rx_dec_out.valid === 1'b1) d = rx_dec_out;
            if (tx && tx_dec_out.valid === 1'b1) d = tx_dec_out;
            if (tx_res_out.valid === 1'b1) r = tx_res_out;
        end
    endtask

    // ===========================================================
    // main sequence
    initial begin
        reset_in = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        ecc_err  = 2'b00;
        wrap_wr  = '0;
        fail_sel = 3'h7;
        soft_err = 1'b0;
        do_reset();
        `CHK("hard_err", 1'b0, hard_err_out)
        wait_boot();
        `CHK("status", 32'h0000_0004, rdat)
        rd(ipc_pkg::A_IRQ_ST);
        `CHK("irq_st", 32'h0000_0001, rdat)
        `CHK("irq_masked", 1'b0, irq_out)
        wr(ipc_pkg::A_IRQ_EN, 32'h0000_000F);
        rd(ipc_pkg::A_IRQ_EN);
        `CHK("irq_en", 32'h0000_000F, rdat)
        `CHK("irq_on", 1'b1, irq_out)
        wr(ipc_pkg::A_IRQ_CL, 32'h0000_0001);
        rd(ipc_pkg::A_IRQ_ST);
        `CHK("irq_clr", 32'h0000_0000, rdat)
        `CHK("irq_off", 1'b0, irq_out)
        for (i = 0; i < 16; i++)
            wr(ipc_pkg::A_MKEY + 8'(4 * i), 32'hC3C3_0000 + i);
        for (i = 0; i < 16; i++) begin
            rd(ipc_pkg::A_MKEY + 8'(4 * i));
            `CHK("key_word", 32'h0000_0000, rdat)
        end
        `CHK("mkey_use", 32'hC3C3_0000, dp_keys_out.master_key[31:0])
        `CHK("wkey_use", 32'hC3C3_0008, dp_keys_out.wrap_key[31:0])
        rd(8'hF0);
        `CHK("unmapped", 32'h0000_0000, rdat)
        wr(ipc_pkg::A_CTRL, 32'h0000_0001);
        repeat (4) @(posedge ref_clk_in);
        `CHK("kdf_start", 1, kdf_seen)
        for (i = 0; i < 32; i++) begin
            soft_err = i[1] ^ i[0];
            ex = i[3] & i[2] & (i[1:0] != 2'h0);
            pkt(i[4], {1'b1, 4'(i)});
            `CHK("dec_valid", 1'b1, d.valid)
            `CHK("dec_crypto", ex, d.crypto)
            if (!i[4]) `CHK("crypto_status", ex, d.flag)
            else begin
                `CHK("bypass_drop", 1'b0, d.flag)
                `CHK("res_valid", ex, r.valid)
                if (ex) `CHK("drop", soft_err, r.flag)
            end
        end
        dbq.delete();
        wr(ipc_pkg::A_DEL, 32'h0000_0120);
        repeat (12) @(posedge ref_clk_in);
        `CHK("del_words", 8, dbq.size())
        foreach (dbq[k]) begin
            `CHK("del_addr", 16'h0120 + k, dbq[k].addr)
            `CHK("del_data", 32'h0000_0000, dbq[k].data)
        end
        rd(ipc_pkg::A_IRQ_ST);
        `CHK("irq_del", 32'h0000_0008, rdat)
        dbq.delete();
        wrap_wr <= {1'b1, 16'h0040, 32'hA5A5_5A5A};
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk_in);
            if (wrap_ready_out === 1'b1) break;
        end
        wrap_wr <= {1'b0, 16'hFFBF, 32'h5A5A_A5A5};
        if (i == 20) begin
            fails++;
            end_of_test();
        end
        repeat (3) @(posedge ref_clk_in);
        `CHK("wrap_words", 1, dbq.size())
        if (dbq.size() > 0) begin
            `CHK("wrap_data", 32'hA5A5_5A5A, dbq[0].data)
            `CHK("wrap_addr", 16'h0040, dbq[0].addr)
        end
        ecc_err <= 2'h1;
        @(posedge ref_clk_in);
        ecc_err <= 2'h0;
        pkt(1'b0, 5'h1D);
        `CHK("hard_err", 1'b1, hard_err_out)
        `CHK("frozen", 1'b0, d.valid)
        rd(ipc_pkg::A_STATUS);
        `CHK("hard_state", 32'h0000_0010, rdat)
        rd(ipc_pkg::A_IRQ_ST);
        `CHK("irq_ecc", 32'h0000_000C, rdat)
        `CHK("irq_fatal", 1'b1, irq_out)
        fail_sel = 3'h2;
        do_reset();
        `CHK("hard_clr", 1'b0, hard_err_out)
        `CHK("irq_rst", 1'b0, irq_out)
        wait_boot();
        `CHK("fail_state", 32'h0000_0068, rdat)
        rd(ipc_pkg::A_IRQ_ST);
        `CHK("irq_fail", 32'h0000_0002, rdat)
        pkt(1'b0, 5'h1D);
        `CHK("no_traffic", 1'b0, d.valid)
        dbq.delete();
        wr(ipc_pkg::A_DEL, 32'h0000_0200);
        repeat (12) @(posedge ref_clk_in);
        `CHK("no_delete", 0, dbq.size())
        `CHK("keys_idle", 512'h0, dp_keys_out)
        end_of_test();
    end
endmodule
